// ===== logic/cdt_tile.sv
// Configurable 8-bit datapath tile with byte queues and status/control
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/100ps
module cdt_tile import cdt_pkg::*; #(
  parameter int QUEUE_DEPTH = QUEUE_DEPTH_DEF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register port
  input wire cdt_bus_req_t busReq,
  output logic [15:0] busRdData,
  // Routing fabric
  input wire cdt_route_in_t routeIn,
  output logic [OUT_N-1:0] routeOut,
  input wire logic [7:0] statusIn,
  output logic [7:0] ctrlOut,
  // Neighbour tiles
  input wire cdt_chain_t chainIn,
  output cdt_chain_t chainOut
);

  cdt_state_t st_reg;
  cdt_state_t st_next;
  logic [1:0] qPush, qPop, qFlush, qEmpty, qFull;
  logic [1:0][7:0] qIn, qHead;

  // Operand decode, shared by the ALU and both comparators
  function automatic logic [7:0] srcSel(input cdt_src_t s, input cdt_state_t st);
    case (s)
      SRC_A0: srcSel = st.a0;
      SRC_A1: srcSel = st.a1;
      SRC_D0: srcSel = st.d0;
      default: srcSel = st.d1;
    endcase
  endfunction

  //==========================================================================
  // Byte queues
  for (genvar i = 0; i < 2; i++) begin : gQueue
    cdt_byte_queue #(.W(DATA_W), .DEPTH(QUEUE_DEPTH)) uQueue (
      .mclk(mclk),
      .reset(reset),
      .push(qPush[i]),
      .pushData(qIn[i]),
      .pop(qPop[i]),
      .popData(qHead[i]),
      .flush(qFlush[i]),
      .empty(qEmpty[i]),
      .full(qFull[i])
    );
  end

  assign busRdData = st_reg.rdData;
  assign routeOut = st_reg.rOut;
  assign ctrlOut = st_reg.ctrl;

  //==========================================================================
  // Datapath, conditions and register port
  cdt_cfg_t cfg;
  cdt_cond_t cond;
  logic dpEn, scEn, cin, cout, shIn, shOut, fb, ov, wrQ, rdQ;
  logic [7:0] wmask, opA, opB, res, outv, cmpA0, cmpB0, cmpA1, cmpB1, stView;
  logic [8:0] sum;
  logic [15:0] rdVal;

  always_comb begin
    st_next = st_reg;
    cfg = cdt_cfg_t'(st_reg.cfgMem[routeIn.cfgAddr]);
    dpEn = st_reg.clkEn[CLKEN_DP];
    scEn = st_reg.clkEn[CLKEN_SC];
    wmask = 8'hFF >> (3'h7 - st_reg.msb);
    opA = srcSel(cfg.srcA, st_reg) & wmask;
    opB = srcSel(cfg.srcB, st_reg) & wmask;
    // Registered carry lets two register sets share one ALU
    if (cfg.carrySel) begin
      cin = st_reg.carry;
    end else begin
      cin = st_reg.chainCfg[CH_CARRY] ? chainIn.carry : routeIn.carryIn;
    end
    shIn = st_reg.chainCfg[CH_SHIFT] ? chainIn.shift : routeIn.shiftIn;
    // Eight operations, one per cycle
    case (cfg.op)
      ALU_INC: sum = {1'b0, opA} + 9'h001;
      ALU_DEC: sum = {1'b0, opA} - 9'h001;
      ALU_ADD: sum = {1'b0, opA} + {1'b0, opB} + {8'h00, cin};
      ALU_SUB: sum = {1'b0, opA} - {1'b0, opB} - {8'h00, cin};
      ALU_AND: sum = {1'b0, opA & opB};
      ALU_OR: sum = {1'b0, opA | opB};
      ALU_XOR: sum = {1'b0, opA ^ opB};
      default: sum = {1'b0, opA};
    endcase
    // Carry is taken just above the programmed top bit
    cout = sum[{1'b0, st_reg.msb} + 4'h1];
    res = sum[7:0] & wmask;
    // Signed overflow only means something for add and subtract
    ov = 1'b0;
    if (cfg.op == ALU_ADD) begin
      ov = (opA[st_reg.msb] == opB[st_reg.msb]) && (res[st_reg.msb] != opA[st_reg.msb]);
    end else if (cfg.op == ALU_SUB) begin
      ov = (opA[st_reg.msb] != opB[st_reg.msb]) && (res[st_reg.msb] != opA[st_reg.msb]);
    end
    // Shift stage runs regardless of the ALU operation
    shOut = 1'b0;
    case (cfg.shift)
      SH_LEFT: begin
        shOut = res[st_reg.msb];
        outv = ((res << 1) | {7'h00, shIn}) & wmask;
      end
      SH_RIGHT: begin
        shOut = res[0];
        outv = (res >> 1) | (shIn ? (8'h01 << st_reg.msb) : 8'h00);
      end
      SH_SWAP: outv = {res[3:0], res[7:4]};
      default: outv = res;
    endcase
    if (cfg.maskEn) begin
      outv = outv | st_reg.orMask;
    end
    // CRC step; a sequence generator simply holds its serial input low
    fb = opA[st_reg.msb] ^ (st_reg.chainCfg[CH_SHIFT] ? chainIn.shift : routeIn.crcIn);
    if (cfg.crcEn) begin
      shOut = opA[st_reg.msb];
      outv = ((opA << 1) & wmask) ^ (fb ? (st_reg.poly & wmask) : 8'h00);
    end

    // Datapath state moves only while its enable is set
    if (dpEn) begin
      st_next.carry = cout;
      st_next.shiftOut = shOut;
      if (cfg.dest == DST_A0 || cfg.dest == DST_BOTH) begin
        st_next.a0 = outv;
      end
      if (cfg.dest == DST_A1 || cfg.dest == DST_BOTH) begin
        st_next.a1 = outv;
      end
    end

    // Queue traffic; bus decode first, datapath side after
    wrQ = busReq.wr && (busReq.addr == ADDR_QUEUE0 || busReq.addr == ADDR_QUEUE1);
    rdQ = busReq.rd && (busReq.addr == ADDR_QUEUE0 || busReq.addr == ADDR_QUEUE1);
    qFlush = (busReq.wr && busReq.addr == ADDR_QCTRL) ?
      busReq.wrData[QC_FLUSH_LSB +: 2] : 2'b00;
    qIn[0] = st_reg.qDir[0] ? st_reg.a0 : busReq.wrData[7:0];
    qIn[1] = st_reg.qDir[1] ? outv : busReq.wrData[7:0];
    for (int i = 0; i < 2; i++) begin
      if (st_reg.qDir[i]) begin
        // Output queue: datapath fills, bus drains
        qPush[i] = dpEn && (i == 0 ? cfg.q0Op : cfg.q1Op);
        qPop[i] = rdQ && (busReq.addr[0] == 1'(i));
      end else begin
        // Input queue: bus fills, datapath drains into a data register
        qPush[i] = wrQ && (busReq.addr[0] == 1'(i));
        qPop[i] = dpEn && (i == 0 ? cfg.q0Op : cfg.q1Op);
      end
    end
    if (!st_reg.qDir[0] && qPop[0] && !qEmpty[0]) begin
      st_next.d0 = qHead[0];
    end
    if (!st_reg.qDir[1] && qPop[1] && !qEmpty[1]) begin
      st_next.d1 = qHead[1];
    end

    // Comparators with per-comparator masks
    cmpA0 = (st_reg.cmpCfg[2] ? st_reg.a1 : st_reg.a0) & st_reg.cmpMask0;
    cmpB0 = srcSel(cdt_src_t'(st_reg.cmpCfg[1:0]), st_reg) & st_reg.cmpMask0;
    cmpA1 = (st_reg.cmpCfg[5] ? st_reg.a1 : st_reg.a0) & st_reg.cmpMask1;
    cmpB1 = srcSel(cdt_src_t'(st_reg.cmpCfg[4:3]), st_reg) & st_reg.cmpMask1;
    cond.constZero = 1'b0;
    cond.cmp0Eq = (cmpA0 == cmpB0) && (!st_reg.chainCfg[CH_COND] || chainIn.cond);
    cond.cmp0Lt = cmpA0 < cmpB0;
    cond.cmp1Eq = cmpA1 == cmpB1;
    cond.cmp1Lt = cmpA1 < cmpB1;
    cond.zero0 = (st_reg.a0 & wmask) == 8'h00;
    cond.zero1 = (st_reg.a1 & wmask) == 8'h00;
    cond.ones0 = (st_reg.a0 & wmask) == wmask;
    cond.ones1 = (st_reg.a1 & wmask) == wmask;
    cond.overflow = ov;
    cond.carryReg = st_reg.carry;
    cond.shiftOut = st_reg.shiftOut;
    cond.q0Empty = qEmpty[0];
    cond.q0Full = qFull[0];
    cond.q1Empty = qEmpty[1];
    cond.q1Full = qFull[1];
    // Each of the six outputs picks one condition or serial bit
    for (int k = 0; k < OUT_N; k++) begin
      st_next.rOut[k] = cond[st_reg.outSel[k*SEL_W +: SEL_W]];
    end

    // Status: transparent bits follow routing, latched bits hold events
    stView = (statusIn & ~st_reg.latchMask) | (st_reg.latched & st_reg.latchMask);
    if (busReq.rd && busReq.addr == ADDR_STATUS) begin
      st_next.latched = st_reg.latched & ~st_reg.latchMask;
    end
    if (scEn) begin
      st_next.latched = st_next.latched | (statusIn & st_reg.latchMask);
    end

    // Register writes; a bus write beats a datapath write to the same register
    if (busReq.wr) begin
      if (busReq.addr <= ADDR_CFG_LAST) begin
        st_next.cfgMem[busReq.addr[2:0]] = busReq.wrData;
      end
      case (busReq.addr)
        ADDR_ACC0: st_next.a0 = busReq.wrData[7:0];
        ADDR_ACC1: st_next.a1 = busReq.wrData[7:0];
        ADDR_DREG0: st_next.d0 = busReq.wrData[7:0];
        ADDR_DREG1: st_next.d1 = busReq.wrData[7:0];
        ADDR_QCTRL: st_next.qDir = busReq.wrData[1:0];
        ADDR_CMASK0: st_next.cmpMask0 = busReq.wrData[7:0];
        ADDR_CMASK1: st_next.cmpMask1 = busReq.wrData[7:0];
        ADDR_ORMASK: st_next.orMask = busReq.wrData[7:0];
        ADDR_MSBPOS: st_next.msb = busReq.wrData[2:0];
        ADDR_POLY: st_next.poly = busReq.wrData[7:0];
        ADDR_OUTSEL: st_next.outSel = {busReq.wrData[7:0], st_reg.outSel[15:0]};
        ADDR_CTRL: st_next.ctrl = busReq.wrData[7:0];
        ADDR_LATCH: st_next.latchMask = busReq.wrData[7:0];
        ADDR_CLKEN: st_next.clkEn = busReq.wrData[1:0];
        ADDR_CHAIN: st_next.chainCfg = busReq.wrData[2:0];
        ADDR_CMPCFG: st_next.cmpCfg = busReq.wrData[5:0];
        default: st_next.clkEn = st_next.clkEn;
      endcase
    end
    // The low selector half shares the offset below with the top byte
    if (busReq.wr && busReq.addr == ADDR_OUTSEL && busReq.wrData[15]) begin
      st_next.outSel = {st_reg.outSel[23:16], 1'b0, busReq.wrData[14:0]};
    end

    // Read mux; unmapped offsets answer zero
    rdVal = 16'h0000;
    if (busReq.addr <= ADDR_CFG_LAST) begin
      rdVal = st_reg.cfgMem[busReq.addr[2:0]];
    end
    case (busReq.addr)
      ADDR_ACC0: rdVal = {8'h00, st_reg.a0};
      ADDR_ACC1: rdVal = {8'h00, st_reg.a1};
      ADDR_DREG0: rdVal = {8'h00, st_reg.d0};
      ADDR_DREG1: rdVal = {8'h00, st_reg.d1};
      ADDR_QUEUE0: rdVal = st_reg.qDir[0] && !qEmpty[0] ? {8'h00, qHead[0]} : 16'h0000;
      ADDR_QUEUE1: rdVal = st_reg.qDir[1] && !qEmpty[1] ? {8'h00, qHead[1]} : 16'h0000;
      ADDR_QCTRL: rdVal = {14'h0000, st_reg.qDir};
      ADDR_QSTAT: rdVal = {12'h000, qFull[1], qEmpty[1], qFull[0], qEmpty[0]};
      ADDR_CMASK0: rdVal = {8'h00, st_reg.cmpMask0};
      ADDR_CMASK1: rdVal = {8'h00, st_reg.cmpMask1};
      ADDR_ORMASK: rdVal = {8'h00, st_reg.orMask};
      ADDR_MSBPOS: rdVal = {13'h0000, st_reg.msb};
      ADDR_POLY: rdVal = {8'h00, st_reg.poly};
      ADDR_OUTSEL: rdVal = {8'h00, st_reg.outSel[23:16]};
      ADDR_CTRL: rdVal = {8'h00, st_reg.ctrl};
      ADDR_STATUS: rdVal = {8'h00, stView};
      ADDR_LATCH: rdVal = {8'h00, st_reg.latchMask};
      ADDR_CLKEN: rdVal = {14'h0000, st_reg.clkEn};
      ADDR_CHAIN: rdVal = {13'h0000, st_reg.chainCfg};
      ADDR_CMPCFG: rdVal = {10'h000, st_reg.cmpCfg};
      default: rdVal = rdVal;
    endcase
    st_next.rdData = busReq.rd ? rdVal : 16'h0000;
  end

  // Chain signals stay combinational so a ripple carry settles in one cycle
  always_comb begin
    chainOut.carry = cout;
    chainOut.shift = shOut;
    chainOut.cond = cond.cmp0Eq;
  end

  //==========================================================================
  // State register
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.cmpMask0 <= RST_MASK;
      st_reg.cmpMask1 <= RST_MASK;
      st_reg.msb <= RST_MSB;
      st_reg.poly <= RST_POLY;
      st_reg.cmpCfg <= RST_CMPCFG;
      st_reg.clkEn <= RST_CLKEN;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

// ===== logic/cdt_pkg.sv
// Constants and types shared by the configurable datapath tile
//==========================================================================
// Functional notes
// - Eight 16-bit configuration words, routing-selected per cycle
// - ALU: inc, dec, add, sub, and, or, xor, pass
// - Separate shift, nibble swap, OR mask stage
// - Two masked comparators over accumulators and data registers
// - Zero, ones, overflow conditions selectable onto routing
// - Programmable MSB for arithmetic and shifts
// - One CRC or sequence step per cycle
// - Each byte queue independently input or output
// - Queue status selectable as datapath outputs
// - Carry, shift, condition chained to neighbour tiles
// - Registered carry and shift out reusable later
// - Six routing inputs and six routing outputs
// - Each routing output picks condition or serial data
// - Control register bits drive routing signals
// - Status register read-only, shows routing signals
// - Status bit may latch until read clears
// - Datapath and status latching have own clock enables
// - Eight-bit ALU, one operation per cycle
// - Accumulators are sinks; data registers sources only
// - Queues load registers, capture accumulator or ALU
package cdt_pkg;

  //==========================================================================
  // Sizes
  localparam int DATA_W = 8;
  localparam int CFG_DEPTH = 8;
  localparam int QUEUE_DEPTH_DEF = 4;
  localparam int OUT_N = 6;
  localparam int SEL_W = 4;

  //==========================================================================
  // Register offsets on the plain register port
  localparam logic [5:0] ADDR_CFG_LAST = 6'h07;
  localparam logic [5:0] ADDR_ACC0 = 6'h08;
  localparam logic [5:0] ADDR_ACC1 = 6'h09;
  localparam logic [5:0] ADDR_DREG0 = 6'h0A;
  localparam logic [5:0] ADDR_DREG1 = 6'h0B;
  localparam logic [5:0] ADDR_QUEUE0 = 6'h0C;
  localparam logic [5:0] ADDR_QUEUE1 = 6'h0D;
  localparam logic [5:0] ADDR_QCTRL = 6'h0E;
  localparam logic [5:0] ADDR_QSTAT = 6'h0F;
  localparam logic [5:0] ADDR_CMASK0 = 6'h10;
  localparam logic [5:0] ADDR_CMASK1 = 6'h11;
  localparam logic [5:0] ADDR_ORMASK = 6'h12;
  localparam logic [5:0] ADDR_MSBPOS = 6'h13;
  localparam logic [5:0] ADDR_POLY = 6'h14;
  localparam logic [5:0] ADDR_OUTSEL = 6'h15;
  localparam logic [5:0] ADDR_CTRL = 6'h16;
  localparam logic [5:0] ADDR_STATUS = 6'h17;
  localparam logic [5:0] ADDR_LATCH = 6'h18;
  localparam logic [5:0] ADDR_CLKEN = 6'h19;
  localparam logic [5:0] ADDR_CHAIN = 6'h1A;
  localparam logic [5:0] ADDR_CMPCFG = 6'h1B;

  //==========================================================================
  // Field positions and reset values
  localparam int CLKEN_DP = 0;
  localparam int CLKEN_SC = 1;
  localparam int CH_CARRY = 0;
  localparam int CH_SHIFT = 1;
  localparam int CH_COND = 2;
  localparam int QC_FLUSH_LSB = 2;
  localparam logic [2:0] RST_MSB = 3'h7;
  localparam logic [7:0] RST_POLY = 8'h1D;
  localparam logic [7:0] RST_MASK = 8'hFF;
  localparam logic [5:0] RST_CMPCFG = 6'h3A;
  localparam logic [1:0] RST_CLKEN = 2'h3;

  //==========================================================================
  // Enumerations
  typedef enum logic [2:0] {
    ALU_PASS, ALU_INC, ALU_DEC, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR
  } cdt_alu_op_t;
  typedef enum logic [1:0] {SH_NONE, SH_LEFT, SH_RIGHT, SH_SWAP} cdt_shift_t;
  typedef enum logic [1:0] {SRC_A0, SRC_A1, SRC_D0, SRC_D1} cdt_src_t;
  typedef enum logic [1:0] {DST_NONE, DST_A0, DST_A1, DST_BOTH} cdt_dest_t;

  //==========================================================================
  // Carriers
  typedef struct packed {
    logic maskEn;
    logic q1Op;
    logic q0Op;
    logic crcEn;
    logic carrySel;
    cdt_dest_t dest;
    cdt_shift_t shift;
    cdt_src_t srcB;
    cdt_src_t srcA;
    cdt_alu_op_t op;
  } cdt_cfg_t;

  typedef struct packed {
    logic crcIn;
    logic carryIn;
    logic shiftIn;
    logic [2:0] cfgAddr;
  } cdt_route_in_t;

  typedef struct packed {
    logic carry;
    logic shift;
    logic cond;
  } cdt_chain_t;

  typedef struct packed {
    logic [5:0] addr;
    logic [15:0] wrData;
    logic wr;
    logic rd;
  } cdt_bus_req_t;

  // Index 0 is constant zero, so a cleared selector drives a quiet output
  typedef struct packed {
    logic q1Full, q1Empty, q0Full, q0Empty;
    logic shiftOut, carryReg, overflow, ones1;
    logic ones0, zero1, zero0, cmp1Lt;
    logic cmp1Eq, cmp0Lt, cmp0Eq, constZero;
  } cdt_cond_t;

  typedef struct packed {
    logic [CFG_DEPTH-1:0][15:0] cfgMem;
    logic [7:0] a0, a1, d0, d1;
    logic carry, shiftOut;
    logic [7:0] cmpMask0, cmpMask1, orMask, poly, ctrl, latched, latchMask;
    logic [2:0] msb;
    logic [OUT_N*SEL_W-1:0] outSel;
    logic [1:0] clkEn, qDir;
    logic [2:0] chainCfg;
    logic [5:0] cmpCfg;
    logic [OUT_N-1:0] rOut;
    logic [15:0] rdData;
  } cdt_state_t;

endpackage

// ===== logic/cdt_byte_queue.sv
// Small byte queue with flush, honest empty and full
`timescale 1ns/100ps
module cdt_byte_queue import cdt_pkg::*; #(
  parameter int W = DATA_W,
  parameter int DEPTH = QUEUE_DEPTH_DEF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Fill side
  input wire logic push,
  input wire logic [W-1:0] pushData,
  // Drain side
  input wire logic pop,
  output logic [W-1:0] popData,
  // Flush and status
  input wire logic flush,
  output logic empty,
  output logic full
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wrPtr, rdPtr;
    logic [CW-1:0] count;
  } cdt_queue_state_t;

  cdt_queue_state_t q_reg;
  cdt_queue_state_t q_next;
  logic doPush;
  logic doPop;

  assign empty = (q_reg.count == '0);
  assign full = (q_reg.count == CW'(DEPTH));
  assign popData = q_reg.mem[q_reg.rdPtr];

  // Refused moves are dropped here so callers need not guard them
  always_comb begin
    q_next = q_reg;
    doPush = push && !full;
    doPop = pop && !empty;
    if (doPush) begin
      q_next.mem[q_reg.wrPtr] = pushData;
      q_next.wrPtr = (q_reg.wrPtr == PW'(DEPTH - 1)) ? '0 : q_reg.wrPtr + 1'b1;
    end
    if (doPop) begin
      q_next.rdPtr = (q_reg.rdPtr == PW'(DEPTH - 1)) ? '0 : q_reg.rdPtr + 1'b1;
    end
    q_next.count = q_reg.count + CW'(doPush) - CW'(doPop);
    if (flush) begin
      q_next.wrPtr = '0;
      q_next.rdPtr = '0;
      q_next.count = '0;
    end
  end

  // Reset clears the contents too; a flush clears only pointers and count
  always_ff @(posedge mclk) begin
    if (reset) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

endmodule

// ===== testbench/cdt_tile_monitor.sv
// Assertion checker for the datapath tile register port and routing outputs
`timescale 1ns/100ps
module cdt_tile_monitor import cdt_pkg::*; #(
  parameter int QUEUE_DEPTH = QUEUE_DEPTH_DEF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register port
  input wire cdt_bus_req_t busReq,
  input wire logic [15:0] busRdData,
  // Routing fabric and neighbours
  input wire cdt_route_in_t routeIn,
  input wire logic [OUT_N-1:0] routeOut,
  input wire logic [7:0] statusIn,
  input wire logic [7:0] ctrlOut,
  input wire cdt_chain_t chainIn,
  input wire cdt_chain_t chainOut
);
  //==========================================================================
  // Shadows of the output selectors and queue directions, kept from bus writes
  logic [OUT_N*SEL_W-1:0] outSel_reg;
  logic [1:0] qDir_reg;
  logic [OUT_N-1:0] quietMask;
  wire logic rdStat = busReq.rd && busReq.addr == ADDR_STATUS;

  // Written twice apart because one offset carries two halves of the selector
  always_ff @(posedge mclk) begin
    if (reset) begin
      outSel_reg <= '0;
      qDir_reg <= 2'h0;
    end else if (busReq.wr && busReq.addr == ADDR_OUTSEL) begin
      if (busReq.wrData[15]) begin
        outSel_reg[15:0] <= {1'b0, busReq.wrData[14:0]};
      end else begin
        outSel_reg[23:16] <= busReq.wrData[7:0];
      end
    end else if (busReq.wr && busReq.addr == ADDR_QCTRL) begin
      qDir_reg <= busReq.wrData[1:0];
    end
  end

  // A cleared selector means a quiet output
  always_comb begin
    for (int k = 0; k < OUT_N; k++) begin
      quietMask[k] = (outSel_reg[k*SEL_W +: SEL_W] == 4'h0);
    end
  end

  //==========================================================================
  // Properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_ctrl_follows_write: assert property (busReq.wr && busReq.addr == ADDR_CTRL
    |=> ctrlOut == $past(busReq.wrData[7:0])) else $error("control output missed a write");
  a_ctrl_holds: assert property (!(busReq.wr && busReq.addr == ADDR_CTRL)
    |=> $stable(ctrlOut)) else $error("control output moved without a write");
  a_ctrl_readback: assert property (busReq.rd && busReq.addr == ADDR_CTRL
    |=> busRdData == {8'h00, ctrlOut}) else $error("control read differs from output");
  a_rd_quiet: assert property (!busReq.rd |=> busRdData == 16'h0000)
    else $error("read data present without a read");
  a_status_upper: assert property (rdStat |=> busRdData[15:8] == 8'h00)
    else $error("status read has upper bits set");
  a_status_clears: assert property ((rdStat && statusIn == 8'h00) ##1
    (statusIn == 8'h00) ##1 (rdStat && statusIn == 8'h00) |=> busRdData[7:0] == 8'h00)
    else $error("latched status survived a read");
  a_quiet_output: assert property (1'b1 |=> (routeOut & $past(quietMask)) == 6'h00)
    else $error("unselected routing output is high");
  a_outsel_read: assert property (busReq.rd && busReq.addr == ADDR_OUTSEL
    |=> busRdData == {8'h00, outSel_reg[23:16]}) else $error("selector readback wrong");
  a_qstat_sane: assert property (busReq.rd && busReq.addr == ADDR_QSTAT
    |=> busRdData[15:4] == 12'h000 && !(busRdData[1] && busRdData[0])
    && !(busRdData[3] && busRdData[2])) else $error("queue status inconsistent");
  a_inq_read_zero: assert property (busReq.rd && busReq.addr == ADDR_QUEUE0
    && !qDir_reg[0] |=> busRdData == 16'h0000) else $error("input queue gave bus data");

  c_status_read: cover property (rdStat ##1 busRdData[0]);
  c_queue_full: cover property (busReq.rd && busReq.addr == ADDR_QSTAT ##1 busRdData[1]);
  c_ctrl_write: cover property (busReq.wr && busReq.addr == ADDR_CTRL);
endmodule

bind cdt_tile cdt_tile_monitor #(.QUEUE_DEPTH(QUEUE_DEPTH)) u_mon (.mclk(mclk), .reset(reset),
  .busReq(busReq), .busRdData(busRdData), .routeIn(routeIn), .routeOut(routeOut),
  .statusIn(statusIn), .ctrlOut(ctrlOut), .chainIn(chainIn), .chainOut(chainOut));

// ===== testbench/cdt_fabric_model.sv
// Routing fabric model: configuration address, status levels and idle chain inputs
`timescale 1ns/100ps
module cdt_fabric_model import cdt_pkg::*; (
  // Clock
  input wire logic mclk,
  // Toward the tile
  output cdt_route_in_t routeIn,
  output logic [7:0] statusIn,
  output cdt_chain_t chainIn,
  // From the tile
  input wire logic [OUT_N-1:0] routeOut,
  input wire logic [7:0] ctrlOut,
  input wire cdt_chain_t chainOut
);
  //==========================================================================
  // Serial and chain inputs stay idle; carry-in changes only with an operation
  initial begin
    routeIn = '0;
    statusIn = 8'h00;
    chainIn = '0;
  end

  // Select one configuration word for exactly one cycle, then fall back to word 0
  task automatic runCfg(input logic [2:0] k, input logic c = 1'b0);
    @(posedge mclk);
    routeIn.cfgAddr <= k;
    routeIn.carryIn <= c;
    @(posedge mclk);
    routeIn.cfgAddr <= 3'h0;
  endtask

  // Status levels change just after an edge
  task automatic setStatus(input logic [7:0] v);
    @(posedge mclk);
    statusIn <= v;
  endtask
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench for the configurable datapath tile
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp=%0h got=%0h", nm, e, g); end end
module tb_top import cdt_pkg::*;;
  //==========================================================================
  // Signals and bookkeeping
  logic mclk;
  logic reset;
  cdt_bus_req_t busReq;
  logic [15:0] busRdData;
  cdt_route_in_t routeIn;
  logic [OUT_N-1:0] routeOut;
  logic [7:0] statusIn;
  logic [7:0] ctrlOut;
  cdt_chain_t chainIn;
  cdt_chain_t chainOut;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  int seed = 2;
  logic [15:0] expQ[$];
  logic [5:0] adQ[$];
  logic rdD1 = 1'b0;
  logic [15:0] eVal;
  string eNm;
  logic [7:0] a, b, c, orM, lastRes;
  logic [7:0] qd [4];
  localparam logic [5:0] RST_AD [8] = '{ADDR_CMASK0, ADDR_CMASK1, ADDR_MSBPOS, ADDR_POLY,
    ADDR_CLKEN, ADDR_CMPCFG, ADDR_CTRL, 6'h3F};
  localparam logic [15:0] RST_VAL [8] = '{16'h00FF, 16'h00FF, 16'h0007, 16'h001D,
    16'h0003, 16'h003A, 16'h0000, 16'h0000};
  // Words: ALU ops A0 with D0 into A1, then shifts, swap and masked XOR
  localparam logic [15:0] OPS [12] = '{16'h0440, 16'h0441, 16'h0442, 16'h0443, 16'h0444,
    16'h0445, 16'h0446, 16'h0447, 16'h04C0, 16'h0540, 16'h05C0, 16'h8447};

  cdt_tile #(.QUEUE_DEPTH(QUEUE_DEPTH_DEF)) u_dut (.mclk(mclk), .reset(reset), .busReq(busReq),
    .busRdData(busRdData), .routeIn(routeIn), .routeOut(routeOut), .statusIn(statusIn),
    .ctrlOut(ctrlOut), .chainIn(chainIn), .chainOut(chainOut));
  cdt_fabric_model u_fab (.mclk(mclk), .routeIn(routeIn), .statusIn(statusIn),
    .chainIn(chainIn), .routeOut(routeOut), .ctrlOut(ctrlOut), .chainOut(chainOut));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  //==========================================================================
  // Register port tasks; expected read data is queued before the strobe
  task automatic wrReg(input logic [5:0] ad, input logic [15:0] d);
    @(posedge mclk);
    busReq <= '{addr: ad, wrData: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    busReq.wr <= 1'b0;
  endtask

  task automatic rdReg(input logic [5:0] ad, input logic [15:0] e);
    expQ.push_back(e);
    adQ.push_back(ad);
    @(posedge mclk);
    busReq <= '{addr: ad, wrData: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    busReq.rd <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so it is sampled there
  always @(posedge mclk) begin
    if (rdD1) begin
      eVal = expQ.pop_front();
      eNm = $sformatf("reg %0h", adQ.pop_front());
      `CHK(eNm, eVal, busRdData)
    end
    rdD1 <= busReq.rd && !reset;
  end

  // Routing carry-in adds into ADD and is taken off in SUB
  function automatic logic [7:0] aluExp(input logic [15:0] w, input logic [7:0] x,
                                        input logic [7:0] y, input logic [7:0] c);
    logic [7:0] r;
    case (w[2:0])
      3'h0: r = x;
      3'h1: r = x + 8'h01;
      3'h2: r = x - 8'h01;
      3'h3: r = x + y + c;
      3'h4: r = x - y - c;
      3'h5: r = x & y;
      3'h6: r = x | y;
      default: r = x ^ y;
    endcase
    case (w[8:7])
      2'h1: r = {r[6:0], 1'b0};
      2'h2: r = {1'b0, r[7:1]};
      2'h3: r = {r[3:0], r[7:4]};
      default: r = r;
    endcase
    if (w[15]) begin
      r = r | orM;
    end
    return r;
  endfunction

  task automatic aluStep(input logic [15:0] w);
    a = 8'($random(seed));
    b = 8'($random(seed));
    c = {7'h00, 1'($random(seed))};
    lastRes = aluExp(w, a, b, c);
    wrReg(ADDR_ACC0, {8'h00, a});
    wrReg(ADDR_DREG0, {8'h00, b});
    wrReg(6'h01, w);
    u_fab.runCfg(3'h1, c[0]);
    rdReg(ADDR_ACC1, {8'h00, lastRes});
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Cut a hang short; the full run needs well under this many cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      conclude();
    end
  end

  //==========================================================================
  // Main sequence
  initial begin
    busReq = '0;
    reset = 1'b1;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    orM = 8'($random(seed));
    #1 `CHK("chainOut", 3'h1, chainOut)
    for (int i = 0; i < 8; i++) rdReg(RST_AD[i], RST_VAL[i]);
    wrReg(ADDR_ORMASK, {8'h00, orM});
    for (int i = 0; i < 8; i++) aluStep(OPS[i]);
    for (int i = 8; i < 12; i++) aluStep(OPS[i]);
    // Datapath clock off: a bus write still lands but the op must not run
    wrReg(ADDR_CLKEN, 16'h0002);
    wrReg(ADDR_ACC0, {8'h00, 8'($random(seed))});
    u_fab.runCfg(3'h1);
    rdReg(ADDR_ACC1, {8'h00, lastRes});
    wrReg(ADDR_CLKEN, 16'h0003);
    a = 8'($random(seed));
    wrReg(ADDR_CTRL, {8'h00, a});
    #1 `CHK("ctrlOut", a, ctrlOut)
    rdReg(ADDR_CTRL, {8'h00, a});
    // Bit 0 latches a one-cycle event, bit 7 stays transparent
    wrReg(ADDR_LATCH, 16'h0001);
    u_fab.setStatus(8'h01);
    u_fab.setStatus(8'h00);
    rdReg(ADDR_STATUS, 16'h0001);
    rdReg(ADDR_STATUS, 16'h0000);
    u_fab.setStatus(8'h80);
    rdReg(ADDR_STATUS, 16'h0080);
    // Output 0 shows queue 0 empty; overfill, then drain through the datapath
    wrReg(ADDR_OUTSEL, 16'h800C);
    repeat (2) @(posedge mclk);
    #1 `CHK("routeOut", 6'h01, routeOut)
    for (int i = 0; i < 5; i++) begin
      a = 8'($random(seed));
      if (i < 4) qd[i] = a;
      wrReg(ADDR_QUEUE0, {8'h00, a});
    end
    rdReg(ADDR_QSTAT, 16'h0006);
    #1 `CHK("routeOut", 6'h00, routeOut)
    rdReg(ADDR_QUEUE0, 16'h0000);
    wrReg(6'h02, 16'h2000);
    for (int i = 0; i < 4; i++) begin
      u_fab.runCfg(3'h2);
      rdReg(ADDR_DREG0, {8'h00, qd[i]});
    end
    rdReg(ADDR_QSTAT, 16'h0005);
    repeat (3) @(posedge mclk);
    conclude();
  end
endmodule
